// file: dv/fsr_top_sva.sv
// Purpose: Port-level checks for the shield window and redirect block.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes:   Bound into fsr_top at the foot of this file.
`timescale 1ns/1ns
module fsr_top_sva (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Register bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Flash side
    input wire logic        ext_wr,
    input wire logic        ser_mode,
    input wire logic        ser_chip_erase,
    input wire logic        block_erase_protect,
    input wire logic        boot_cluster_protect,
    input wire logic        programmer_connect_protect,
    input wire logic        chip_erase_go,
    input wire logic        chip_erase_rej,
    // Permission check and vectoring
    input wire logic        chk_req,
    input wire logic        chk_done,
    input wire logic        chk_allowed,
    input wire logic        irq_take,
    input wire logic        vec_use_ram,
    input wire logic [19:0] vec_ram_addr,
    input wire logic        self_prog
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // The guard on self_prog at the answer edge tolerates one cycle of copy delay.
    read_upper_a: assert property ($fell(avs_waitrequest) |->
        avs_readdata[31:16] == 16'h0000) else $error("read data upper half not zero");
    erase_refuse_a: assert property (ser_mode && ser_chip_erase && !(block_erase_protect
        && boot_cluster_protect && programmer_connect_protect) |=> chip_erase_rej && !chip_erase_go)
        else $error("protected chip erase not refused");
    erase_accept_a: assert property (ser_mode && ser_chip_erase && block_erase_protect
        && boot_cluster_protect && programmer_connect_protect |=> chip_erase_go && !chip_erase_rej)
        else $error("unprotected chip erase not accepted");
    erase_cause_a: assert property (chip_erase_go || chip_erase_rej |->
        $past(ser_mode && ser_chip_erase)) else $error("erase answer without request");
    prog_pulse_a: assert property (ext_wr |=> !ext_wr)
        else $error("extra programming pulse too long");
    check_answer_a: assert property (chk_req |=> chk_done)
        else $error("check not answered");
    check_free_a: assert property (chk_req && !self_prog |=> self_prog || chk_allowed)
        else $error("block denied outside self-programming");
    vector_rom_a: assert property (irq_take && !self_prog |=> self_prog || !vec_use_ram)
        else $error("redirect outside self-programming");
    vector_ram_a: assert property (vec_use_ram |-> vec_ram_addr[19:16] == 4'hF)
        else $error("redirect target outside RAM region");
endmodule

bind fsr_top fsr_top_sva u_fsr_top_sva (.ref_clk, .rst, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .ext_wr, .ser_mode, .ser_chip_erase, .block_erase_protect,
    .boot_cluster_protect, .programmer_connect_protect, .chip_erase_go, .chip_erase_rej,
    .chk_req, .chk_done, .chk_allowed, .irq_take, .vec_use_ram, .vec_ram_addr, .self_prog);

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the shield window and redirect block.
// Assumes: Bench plays the CPU on the bus and the flash array on the extra-area pins.
// Notes:   Every wait is bounded; a stalled handshake ends the run as a mismatch.
`timescale 1ns/1ns
`include "fsr_defs.svh"
module tb_top;
    logic        ref_clk, rst, avs_read, avs_write, avs_waitrequest, ext_done, ext_wr;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] ext_end_q, ext_start_q, ext_wr_end, ext_wr_start;
    logic        ser_mode, ser_chip_erase, block_erase_protect, boot_cluster_protect;
    logic        programmer_connect_protect, chip_erase_go, chip_erase_rej;
    logic        chk_req, chk_done, chk_allowed, irq_take, vec_use_ram, self_prog;
    logic [8:0]  chk_block;
    logic [19:0] vec_ram_addr;
    int          error_cnt, cmp_count, i;

    fsr_top u_fsr_top (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .ext_end_q, .ext_start_q, .ext_done, .ext_wr,
        .ext_wr_end, .ext_wr_start, .ser_mode, .ser_chip_erase, .block_erase_protect,
        .boot_cluster_protect, .programmer_connect_protect, .chip_erase_go, .chip_erase_rej,
        .chk_req, .chk_block, .chk_done, .chk_allowed, .irq_take, .vec_use_ram,
        .vec_ram_addr, .self_prog);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request is held until the edge that samples waitrequest low.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n == 20) begin
            error_cnt++;
            end_of_test();
        end
    endtask

    task automatic rd(input string name, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, q, exp);
    endtask

    task automatic pmc_seq(input logic [7:0] v);
        bus(1'b1, `FSR_OFS_PCMD, {24'h000000, `FSR_PCMD_KEY});
        bus(1'b1, `FSR_OFS_PMC, {24'h000000, v});
        bus(1'b1, `FSR_OFS_PMC, {24'h000000, ~v});
        bus(1'b1, `FSR_OFS_PMC, {24'h000000, v});
    endtask

    task automatic chk(input logic [8:0] blk, input logic exp);
        @(posedge ref_clk);
        chk_req <= 1'b1;
        chk_block <= blk;
        @(posedge ref_clk);
        chk_req <= 1'b0;
        @(posedge ref_clk);
        check("chk_done", {31'h0, chk_done}, 32'h1);
        check("chk_allowed", {31'h0, chk_allowed}, {31'h0, exp});
    endtask

    task automatic irq(input logic exp);
        @(posedge ref_clk);
        irq_take <= 1'b1;
        @(posedge ref_clk);
        irq_take <= 1'b0;
        @(posedge ref_clk);
        check("vec_use_ram", {31'h0, vec_use_ram}, {31'h0, exp});
        check("vec_ram_addr", {12'h0, vec_ram_addr}, 32'h000F1234);
    endtask

    // Bench acts as the flash array: it stores the words and reports completion.
    task automatic prog(input logic [15:0] e, input logic [15:0] s, input logic [3:0] md,
                        input logic ok);
        bus(1'b1, `FSR_OFS_XEND, {16'h0000, e});
        bus(1'b1, `FSR_OFS_XSTART, {16'h0000, s});
        bus(1'b1, `FSR_OFS_XSEQ, {27'h0, 1'b1, md});
        for (i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            if (ext_wr === 1'b1) break;
        end
        check("ext_wr", {31'h0, ext_wr}, {31'h0, ok});
        if (ok) begin
            check("ext_wr_data", {ext_wr_end, ext_wr_start}, {e, s});
            rd("busy", `FSR_OFS_STATUS, 32'h1);
            ext_end_q <= e;
            ext_start_q <= s;
            ext_done <= 1'b1;
            @(posedge ref_clk);
            ext_done <= 1'b0;
            rd("end_mon", `FSR_OFS_WEND, {16'h0, e});
            rd("start_mon", `FSR_OFS_WSTART, {16'h0, s});
        end else begin
            rd("refused", `FSR_OFS_STATUS, 32'h2);
            bus(1'b1, `FSR_OFS_STATUS, 32'hF);
        end
    endtask

    task automatic t_registers;
        rd("end_mon", `FSR_OFS_WEND, 32'h8006);
        rd("start_mon", `FSR_OFS_WSTART, 32'h8003);
        rd("pmc", `FSR_OFS_PMC, 32'h08);
        rd("tgt_hi", `FSR_OFS_TGT_HI, 32'h000F);
        rd("tgt_lo", `FSR_OFS_TGT_LO, 32'h0);
        bus(1'b1, `FSR_OFS_WEND, 32'h1234);
        bus(1'b1, `FSR_OFS_WSTART, 32'h0001);
        bus(1'b1, `FSR_OFS_TGT_HI, 32'h0);
        rd("end_mon", `FSR_OFS_WEND, 32'h8006);
        rd("start_mon", `FSR_OFS_WSTART, 32'h8003);
        rd("tgt_hi", `FSR_OFS_TGT_HI, 32'h000F);
        rd("unmapped", 6'h3C, 32'h0);
    endtask

    task automatic t_unlock_redirect;
        pmc_seq(8'h02);
        rd("pmc", `FSR_OFS_PMC, 32'h02);
        check("self_prog", {31'h0, self_prog}, 32'h1);
        bus(1'b1, `FSR_OFS_PMC, 32'h08);
        rd("pmc", `FSR_OFS_PMC, 32'h02);
        rd("seq_err", `FSR_OFS_STATUS, 32'h4);
        bus(1'b1, `FSR_OFS_STATUS, 32'hF);
        bus(1'b1, `FSR_OFS_TGT_LO, 32'h1234);
        bus(1'b1, `FSR_OFS_RDCTL, 32'h01);
        irq(1'b1);
        pmc_seq(8'h0A);
        irq(1'b0);
        pmc_seq(8'h00);
        irq(1'b0);
        pmc_seq(8'h08);
        bus(1'b1, `FSR_OFS_RDCTL, 32'h00);
        rd("rdctl", `FSR_OFS_RDCTL, 32'h0);
    endtask

    task automatic t_window;
        pmc_seq(8'h02);
        for (i = 0; i < 4; i++) chk(9'(i + 2 + (i > 1)), (i == 1) || (i == 2));
        prog(16'h7E06, 16'hFE03, `FSR_XMODE_FSW, 1'b1);
        for (i = 0; i < 4; i++) chk(9'(i + 2 + (i > 1)), (i == 0) || (i == 3));
        prog(16'hFE06, 16'hFE03, 4'h7, 1'b0);
        pmc_seq(8'h00);
        chk(9'h003, 1'b1);
        pmc_seq(8'h02);
        prog(16'hFE04, 16'hFE04, `FSR_XMODE_FSW, 1'b1);
        chk(9'h004, 1'b1);
        chk(9'h1FF, 1'b1);
        prog(16'hFE04, 16'h7E04, `FSR_XMODE_FSW, 1'b1);
        prog(16'hFE06, 16'hFE03, `FSR_XMODE_FSW, 1'b0);
    endtask

    task automatic t_erase;
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            ser_mode <= 1'b1;
            ser_chip_erase <= 1'b1;
            {block_erase_protect, boot_cluster_protect, programmer_connect_protect} <=
                3'(7 >> i) | 3'(7 << (4 - i));
            @(posedge ref_clk);
            ser_chip_erase <= 1'b0;
            @(posedge ref_clk);
            check("erase_go", {31'h0, chip_erase_go}, {31'h0, i == 0});
            check("erase_rej", {31'h0, chip_erase_rej}, {31'h0, i != 0});
        end
        rd("erase_rej_flag", `FSR_OFS_STATUS, 32'h8);
    endtask

    initial begin
        {avs_read, avs_write, ext_done, ser_mode, ser_chip_erase, chk_req, irq_take} = 7'h00;
        {block_erase_protect, boot_cluster_protect, programmer_connect_protect} = 3'h7;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        chk_block = 9'h000;
        ext_end_q = 16'h8006;
        ext_start_q = 16'h8003;
        error_cnt = 0;
        cmp_count = 0;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_registers();
        t_unlock_redirect();
        t_window();
        t_erase();
        end_of_test();
    end
endmodule

// file: rtl/fsr_defs.svh
// Purpose: Offsets, field positions, reset values and codes for the shield/redirect block.
// Assumes: Avalon-MM word addressing in bytes, 32-bit data, registers in the low bits.
// Notes:   Definitions only; the package holds the types.
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

`define FSR_ADDR_W        6
`define FSR_OFS_WEND      6'h00
`define FSR_OFS_WSTART    6'h04
`define FSR_OFS_PMC       6'h08
`define FSR_OFS_PCMD      6'h0C
`define FSR_OFS_TGT_HI    6'h10
`define FSR_OFS_TGT_LO    6'h14
`define FSR_OFS_RDCTL     6'h18
`define FSR_OFS_XEND      6'h1C
`define FSR_OFS_XSTART    6'h20
`define FSR_OFS_XSEQ      6'h24
`define FSR_OFS_STATUS    6'h28

`define FSR_BLK_MSB       8
`define FSR_TOP_BIT       15
`define FSR_RSV_MSB       14
`define FSR_RSV_LSB       9
`define FSR_RSV_ONES      6'h3F

`define FSR_PMC_RESET     8'h08
`define FSR_PMC_WMASK     8'h1A
`define FSR_PMC_FLASH_WRITE_DISABLE    3
`define FSR_PMC_SPM       1
`define FSR_PCMD_KEY      8'hA5

`define FSR_TGT_HI_FIXED  16'h000F
`define FSR_TGT_LO_RESET  16'h0000
`define FSR_RDCTL_RESET   8'h00
`define FSR_RDCTL_EN      0
`define FSR_MON_RESET     16'h0000

`define FSR_XMODE_FSW     4'h1
`define FSR_XSEQ_GO       4

`define FSR_ST_BUSY       0
`define FSR_ST_REFUSED    1
`define FSR_ST_SEQERR     2
`define FSR_ST_CEREJ      3

`endif

// file: rtl/fsr_pkg.sv
// Purpose: Types shared by the shield/redirect block.
// Assumes: Constants live in fsr_defs.svh.
// Notes:   Nothing here is imported; users write fsr_pkg::name.
package fsr_pkg;

    typedef enum logic [1:0] {
        UNLK_IDLE,
        UNLK_ARMED,
        UNLK_FIRST,
        UNLK_INV
    } fsr_unlk_t;

    typedef enum logic {
        XS_IDLE,
        XS_BUSY
    } fsr_xseq_t;

endpackage

// file: rtl/fsr_top.sv
// Purpose: Flash shield window control, window lock and interrupt RAM redirection.
// Assumes: One 25 MHz clock; the flash array sits outside and reports its extra area.
// Notes:   Avalon-MM slave answers every access with exactly one waitrequest-low cycle.
`timescale 1ns/1ns
`include "fsr_defs.svh"

module fsr_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Stored extra-area window settings from the flash array
    input  wire logic [15:0] ext_end_q,
    input  wire logic [15:0] ext_start_q,
    input  wire logic        ext_done,
    // Extra-area programming request to the flash array
    output logic             ext_wr,
    output logic [15:0]      ext_wr_end,
    output logic [15:0]      ext_wr_start,
    // Serial programming mode chip erase
    input  wire logic        ser_mode,
    input  wire logic        ser_chip_erase,
    input  wire logic        block_erase_protect,
    input  wire logic        boot_cluster_protect,
    input  wire logic        programmer_connect_protect,
    output logic             chip_erase_go,
    output logic             chip_erase_rej,
    // Block program/erase permission check
    input  wire logic        chk_req,
    input  wire logic [8:0]  chk_block,
    output logic             chk_done,
    output logic             chk_allowed,
    // Interrupt vectoring
    input  wire logic        irq_take,
    output logic             vec_use_ram,
    output logic [19:0]      vec_ram_addr,
    output logic             self_prog
);

    // Register state.
    logic [15:0]        wend_mon_r;
    logic [15:0]        wstart_mon_r;
    logic               reload_r;
    logic [7:0]         pmc_r;
    logic [7:0]         pmc_stage_r;
    fsr_pkg::fsr_unlk_t unlk_r;
    logic [15:0]        tgt_lo_r;
    logic [7:0]         rdctl_r;
    logic [15:0]        xend_r;
    logic [15:0]        xstart_r;
    logic [3:0]         xmode_r;
    fsr_pkg::fsr_xseq_t xseq_r;
    logic               refused_r;
    logic               seqerr_r;
    logic               cerej_r;

    // Bus handshake state.
    logic        wait_r;
    logic [31:0] rdata_r;
    logic        wr_now;
    logic        rd_first;

    // Decoded window fields and the fixed redirect target high part.
    logic [8:0]  win_end;
    logic [8:0]  win_start;
    logic        shield_out;
    logic        win_locked;
    logic [15:0] tgt_hi;

    assign tgt_hi = `FSR_TGT_HI_FIXED;

    assign win_end    = wend_mon_r[`FSR_BLK_MSB:0];
    assign win_start  = wstart_mon_r[`FSR_BLK_MSB:0];
    assign shield_out = wend_mon_r[`FSR_TOP_BIT];
    assign win_locked = ~wstart_mon_r[`FSR_TOP_BIT];

    // A write takes effect on the single cycle in which waitrequest is low.
    assign wr_now   = avs_write & ~wait_r;
    assign rd_first = (avs_read | avs_write) & wait_r;

    // True when a block falls in the shielded region of the current window.
    function automatic logic in_shield(input logic [8:0] blk, input logic [8:0] ws,
                                       input logic [8:0] we, input logic outside);
        logic in_win;
        in_win = (blk >= ws) && (blk < we);
        if (ws == we) begin
            in_shield = 1'b0;
        end else if (outside) begin
            in_shield = ~in_win;
        end else begin
            in_shield = in_win;
        end
    endfunction

    // True when a bus write to the given offset is in progress this cycle.
    function automatic logic wr_hit(input logic [5:0] adr, input logic [5:0] ofs,
                                    input logic wr);
        wr_hit = wr && (adr == ofs);
    endfunction

    // Avalon handshake: first edge captures read data, second edge completes.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_r <= 1'b1;
        end else if (rd_first) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else if (rd_first && avs_read) begin
            case (avs_address)
                `FSR_OFS_WEND:   rdata_r <= {16'h0000, wend_mon_r};
                `FSR_OFS_WSTART: rdata_r <= {16'h0000, wstart_mon_r};
                `FSR_OFS_PMC:    rdata_r <= {24'h000000, pmc_r};
                `FSR_OFS_TGT_HI: rdata_r <= {16'h0000, `FSR_TGT_HI_FIXED};
                `FSR_OFS_TGT_LO: rdata_r <= {16'h0000, tgt_lo_r};
                `FSR_OFS_RDCTL:  rdata_r <= {24'h000000, rdctl_r};
                `FSR_OFS_XEND:   rdata_r <= {16'h0000, xend_r};
                `FSR_OFS_XSTART: rdata_r <= {16'h0000, xstart_r};
                `FSR_OFS_XSEQ:   rdata_r <= {28'h0000000, xmode_r};
                `FSR_OFS_STATUS: rdata_r <= {28'h0000000, cerej_r, seqerr_r, refused_r,
                                             xseq_r == fsr_pkg::XS_BUSY};
                default:         rdata_r <= 32'h00000000;
            endcase
        end
    end

    // Monitors reload from the stored extra area after reset and after programming.
    // Bus writes never reach them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reload_r <= 1'b1;
        end else begin
            reload_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wend_mon_r   <= `FSR_MON_RESET;
            wstart_mon_r <= `FSR_MON_RESET;
        end else if (reload_r || (xseq_r == fsr_pkg::XS_BUSY && ext_done)) begin
            wend_mon_r   <= ext_end_q;
            wstart_mon_r <= ext_start_q;
        end
    end

    // Protected write to the mode control register: key, value, inverse, value.
    // Any other bus write in between drops the sequence and flags it, except one right after the key, which is not flagged.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unlk_r      <= fsr_pkg::UNLK_IDLE;
            pmc_stage_r <= 8'h00;
            pmc_r       <= `FSR_PMC_RESET;
        end else if (wr_now) begin
            case (unlk_r)
                fsr_pkg::UNLK_IDLE: begin
                    if (wr_hit(avs_address, `FSR_OFS_PCMD, 1'b1) &&
                        avs_writedata[7:0] == `FSR_PCMD_KEY) begin
                        unlk_r <= fsr_pkg::UNLK_ARMED;
                    end
                end
                fsr_pkg::UNLK_ARMED: begin
                    if (wr_hit(avs_address, `FSR_OFS_PMC, 1'b1)) begin
                        pmc_stage_r <= avs_writedata[7:0];
                        unlk_r      <= fsr_pkg::UNLK_FIRST;
                    end else begin
                        unlk_r <= fsr_pkg::UNLK_IDLE;
                    end
                end
                fsr_pkg::UNLK_FIRST: begin
                    if (wr_hit(avs_address, `FSR_OFS_PMC, 1'b1) &&
                        avs_writedata[7:0] == ~pmc_stage_r) begin
                        unlk_r <= fsr_pkg::UNLK_INV;
                    end else begin
                        unlk_r <= fsr_pkg::UNLK_IDLE;
                    end
                end
                fsr_pkg::UNLK_INV: begin
                    if (wr_hit(avs_address, `FSR_OFS_PMC, 1'b1) &&
                        avs_writedata[7:0] == pmc_stage_r) begin
                        pmc_r <= pmc_stage_r & `FSR_PMC_WMASK;
                    end
                    unlk_r <= fsr_pkg::UNLK_IDLE;
                end
                default: begin
                    unlk_r <= fsr_pkg::UNLK_IDLE;
                end
            endcase
        end
    end

    // Sticky sequence-error flag; a new failure in the clearing cycle wins.
    logic seq_fail;
    always_comb begin
        seq_fail = 1'b0;
        if (wr_now && unlk_r == fsr_pkg::UNLK_FIRST) begin
            seq_fail = ~wr_hit(avs_address, `FSR_OFS_PMC, 1'b1) ||
                       avs_writedata[7:0] != ~pmc_stage_r;
        end else if (wr_now && unlk_r == fsr_pkg::UNLK_INV) begin
            seq_fail = ~wr_hit(avs_address, `FSR_OFS_PMC, 1'b1) ||
                       avs_writedata[7:0] != pmc_stage_r;
        end else if (wr_hit(avs_address, `FSR_OFS_PMC, wr_now) &&
                     unlk_r == fsr_pkg::UNLK_IDLE) begin
            seq_fail = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seqerr_r <= 1'b0;
        end else if (seq_fail) begin
            seqerr_r <= 1'b1;
        end else if (wr_hit(avs_address, `FSR_OFS_STATUS, wr_now) &&
                     avs_writedata[`FSR_ST_SEQERR]) begin
            seqerr_r <= 1'b0;
        end
    end

    // Redirect target low part and redirect enable. The high part is a constant.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tgt_lo_r <= `FSR_TGT_LO_RESET;
        end else if (wr_hit(avs_address, `FSR_OFS_TGT_LO, wr_now)) begin
            tgt_lo_r <= avs_writedata[15:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdctl_r <= `FSR_RDCTL_RESET;
        end else if (wr_hit(avs_address, `FSR_OFS_RDCTL, wr_now)) begin
            rdctl_r <= avs_writedata[7:0];
        end
    end

    // Staging registers for an extra-area programming request.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xend_r   <= `FSR_MON_RESET;
            xstart_r <= `FSR_MON_RESET;
            xmode_r  <= 4'h0;
        end else begin
            if (wr_hit(avs_address, `FSR_OFS_XEND, wr_now)) begin
                xend_r <= avs_writedata[15:0];
            end
            if (wr_hit(avs_address, `FSR_OFS_XSTART, wr_now)) begin
                xstart_r <= avs_writedata[15:0];
            end
            if (wr_hit(avs_address, `FSR_OFS_XSEQ, wr_now)) begin
                xmode_r <= avs_writedata[3:0];
            end
        end
    end

    // Extra-area sequencer. While locked, the request is refused and nothing is
    // written, so the lock itself cannot be undone from self-programming.
    logic xgo;
    logic xrefuse;
    assign xgo     = wr_hit(avs_address, `FSR_OFS_XSEQ, wr_now) &&
                     avs_writedata[`FSR_XSEQ_GO] && xseq_r == fsr_pkg::XS_IDLE;
    assign xrefuse = xgo && (win_locked ||
                     avs_writedata[3:0] != `FSR_XMODE_FSW);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xseq_r       <= fsr_pkg::XS_IDLE;
            ext_wr       <= 1'b0;
            ext_wr_end   <= `FSR_MON_RESET;
            ext_wr_start <= `FSR_MON_RESET;
        end else begin
            ext_wr <= 1'b0;
            case (xseq_r)
                fsr_pkg::XS_IDLE: begin
                    if (xgo && !xrefuse) begin
                        ext_wr       <= 1'b1;
                        ext_wr_end   <= xend_r;
                        ext_wr_start <= xstart_r;
                        xseq_r       <= fsr_pkg::XS_BUSY;
                    end
                end
                fsr_pkg::XS_BUSY: begin
                    if (ext_done) begin
                        xseq_r <= fsr_pkg::XS_IDLE;
                    end
                end
                default: begin
                    xseq_r <= fsr_pkg::XS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            refused_r <= 1'b0;
        end else if (xrefuse) begin
            refused_r <= 1'b1;
        end else if (wr_hit(avs_address, `FSR_OFS_STATUS, wr_now) &&
                     avs_writedata[`FSR_ST_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // Serial-mode chip erase is the only path that clears the lock; the array
    // returns shipped settings and the monitors pick them up at the next reset reload.
    logic ce_req;
    logic ce_ok;
    assign ce_req = ser_mode && ser_chip_erase;
    assign ce_ok  = block_erase_protect && boot_cluster_protect &&
                    programmer_connect_protect;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chip_erase_go  <= 1'b0;
            chip_erase_rej <= 1'b0;
        end else begin
            chip_erase_go  <= ce_req && ce_ok;
            chip_erase_rej <= ce_req && !ce_ok;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cerej_r <= 1'b0;
        end else if (ce_req && !ce_ok) begin
            cerej_r <= 1'b1;
        end else if (wr_hit(avs_address, `FSR_OFS_STATUS, wr_now) &&
                     avs_writedata[`FSR_ST_CEREJ]) begin
            cerej_r <= 1'b0;
        end
    end

    // Block permission check, answered one cycle after the request.
    // Outside self-programming the window places no limit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chk_done    <= 1'b0;
            chk_allowed <= 1'b0;
        end else begin
            chk_done <= chk_req;
            if (chk_req) begin
                chk_allowed <= ~(pmc_r[`FSR_PMC_SPM] &&
                                 in_shield(chk_block, win_start, win_end,
                                           shield_out));
            end
        end
    end

    // Vector selection, refreshed on every interrupt taken. Request flags are
    // never touched here; software must clear them after identifying the source.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vec_use_ram  <= 1'b0;
            vec_ram_addr <= 20'h00000;
        end else if (irq_take) begin
            vec_use_ram  <= rdctl_r[`FSR_RDCTL_EN] && !pmc_r[`FSR_PMC_FLASH_WRITE_DISABLE] &&
                            pmc_r[`FSR_PMC_SPM];
            vec_ram_addr <= {tgt_hi[3:0], tgt_lo_r};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            self_prog <= 1'b0;
        end else begin
            self_prog <= pmc_r[`FSR_PMC_SPM];
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

endmodule
